/* core/csoir_regs.sv */
// Core flag and bank select, option and interrupt control registers
`timescale 1ns/100ps
`include "csoir_params.svh"
module csoir_regs
  import csoir_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Instruction stream
  input  wire logic        op_valid,
  input  wire csoir_op_t   op_code,
  input  wire logic        op_lit,
  input  wire logic        op_to_file,
  input  wire logic [6:0]  op_addr,
  input  wire logic [2:0]  op_bit,
  input  wire csoir_byte_t w_val,
  input  wire csoir_byte_t file_val,
  // Core events
  input  wire logic        sleep_exec,
  input  wire logic        clrwdt_exec,
  input  wire logic        wdt_timeout,
  input  wire logic        wdt_osc_tick,
  // Pins and peripheral events
  input  wire logic        ext_irq_pin,
  input  wire logic        timer_clk_pin,
  input  wire logic        timer_ovf,
  input  wire logic        portb_change,
  input  wire logic        periph_irq,
  // Write-back to file and working register
  output csoir_byte_t      wr_data_q,
  output logic [8:0]       wr_addr_q,
  output logic             wr_en_q,
  output csoir_byte_t      w_data_q,
  output logic             w_en_q,
  // Register contents and controls
  output csoir_byte_t      alu_flags_bank_select_q,
  output csoir_byte_t      timer_irq_option_control_q,
  output csoir_byte_t      irq_ctl_reg_q,
  output logic             pullup_en_q,
  output logic             timer_inc_q,
  output logic             wdt_inc_q,
  output logic             irq_q
);

  csoir_alu_if au();

  csoir_alu u_alu (
    .au (au)
  );

  csoir_byte_t afb_d, opt_d, ictl_d, wr_data_d, w_data_d, pre_q, pre_d, pre_term;
  logic [8:0]  dir_addr, wr_addr_d;
  logic        hit_afb, hit_opt, hit_ictl, own_hit, file_wr, any_upd;
  logic        wr_en_d, w_en_d, pullup_en_d, timer_inc_d, wdt_inc_d, irq_d;
  logic        ext_q, tclk_q, ext_edge, t_rise, t_fall, src_evt, pre_evt, pre_tick;

  // Direct address formed from bank bits and the seven-bit field
  assign dir_addr = {alu_flags_bank_select_q[`CSOIR_AFB_BANK_HI:`CSOIR_AFB_BANK_LO],
                     op_addr};
  assign hit_afb  = !op_lit && (op_addr == `CSOIR_AFB_ADDR);
  assign hit_opt  = !op_lit && (dir_addr == `CSOIR_OPT_ADDR_B1 ||
                                dir_addr == `CSOIR_OPT_ADDR_B3);
  assign hit_ictl = !op_lit && (op_addr == `CSOIR_ICTL_ADDR);
  assign own_hit  = hit_afb || hit_opt || hit_ictl;
  assign file_wr  = op_valid && op_to_file && !op_lit;
  assign any_upd  = au.upd_z || au.upd_dc || au.upd_c;

  // Own registers read back as operands in place of the file value
  assign au.op   = op_valid ? op_code : CSOIR_OP_NONE;
  assign au.a    = hit_afb  ? alu_flags_bank_select_q :
                   hit_opt  ? timer_irq_option_control_q :
                   hit_ictl ? irq_ctl_reg_q : file_val;
  assign au.b    = w_val;
  assign au.bsel = op_bit;
  assign au.cin  = alu_flags_bank_select_q[`CSOIR_AFB_OVF];

  // Flags and bank select next value
  always_comb begin
    afb_d = alu_flags_bank_select_q;
    if (file_wr && hit_afb) begin
      afb_d[7:5] = au.res[7:5];
      if (!any_upd)
        afb_d[2:0] = au.res[2:0];
    end
    if (au.upd_z)
      afb_d[`CSOIR_AFB_NULL] = au.z;
    if (au.upd_dc)
      afb_d[`CSOIR_AFB_NIB] = au.dc;
    if (au.upd_c)
      afb_d[`CSOIR_AFB_OVF] = au.c;
    // Watchdog and powerdown flags move only on core events
    if (clrwdt_exec) begin
      afb_d[`CSOIR_AFB_WDEXP] = 1'b1;
      afb_d[`CSOIR_AFB_PWRDN] = 1'b1;
    end
    if (sleep_exec) begin
      afb_d[`CSOIR_AFB_WDEXP] = 1'b1;
      afb_d[`CSOIR_AFB_PWRDN] = 1'b0;
    end
    if (wdt_timeout)
      afb_d[`CSOIR_AFB_WDEXP] = 1'b0;
  end

  // Option and interrupt control next values
  always_comb begin
    opt_d  = timer_irq_option_control_q;
    ictl_d = irq_ctl_reg_q;
    if (file_wr && hit_opt)
      opt_d = au.res;
    if (file_wr && hit_ictl)
      ictl_d = au.res;
    // Hardware set comes after the write so an event is never lost
    if (timer_ovf)
      ictl_d[`CSOIR_ICTL_TMR_FLAG] = 1'b1;
    if (ext_edge)
      ictl_d[`CSOIR_ICTL_EXT_FLAG] = 1'b1;
    if (portb_change)
      ictl_d[`CSOIR_ICTL_PB_FLAG] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_flags_bank_select_q    <= `CSOIR_AFB_RST;
      timer_irq_option_control_q <= `CSOIR_OPT_RST;
      irq_ctl_reg_q              <= `CSOIR_ICTL_RST;
    end else begin
      alu_flags_bank_select_q    <= afb_d;
      timer_irq_option_control_q <= opt_d;
      irq_ctl_reg_q              <= ictl_d;
    end
  end

  // Pin edges; inputs arrive synchronous to core_clk
  always_comb begin
    ext_edge = timer_irq_option_control_q[`CSOIR_OPT_IRQ_EDGE] ?
               (ext_irq_pin && !ext_q) : (!ext_irq_pin && ext_q);
    t_rise   = timer_clk_pin && !tclk_q;
    t_fall   = !timer_clk_pin && tclk_q;
    src_evt  = !timer_irq_option_control_q[`CSOIR_OPT_SRC] ? 1'b1 :
               timer_irq_option_control_q[`CSOIR_OPT_TEDGE] ? t_fall : t_rise;
  end

  // Shared prescaler; watchdog ratios start at 1:1, timer ratios at 1:2
  always_comb begin
    pre_evt  = timer_irq_option_control_q[`CSOIR_OPT_ASSIGN] ? wdt_osc_tick : src_evt;
    pre_term = timer_irq_option_control_q[`CSOIR_OPT_ASSIGN] ?
      (8'h01 << timer_irq_option_control_q[`CSOIR_OPT_RATE_MSB:0]) - 8'h01 :
      (8'h02 << timer_irq_option_control_q[`CSOIR_OPT_RATE_MSB:0]) - 8'h01;
    pre_tick = pre_evt && (pre_q == pre_term);
    pre_d    = pre_q;
    if (pre_evt)
      pre_d = pre_tick ? 8'h00 : pre_q + 8'h01;
    // Restart on every option write, else a stale count could overshoot the new terminal
    if (file_wr && hit_opt)
      pre_d = 8'h00;
  end

  // Outputs registered one cycle after their cause; irq_q one cycle after the irq control register
  always_comb begin
    wr_en_d     = file_wr && !own_hit;
    wr_addr_d   = dir_addr;
    wr_data_d   = au.res;
    w_en_d      = op_valid && !op_to_file;
    w_data_d    = au.res;
    pullup_en_d = !opt_d[`CSOIR_OPT_PULLUP_N];
    timer_inc_d = timer_irq_option_control_q[`CSOIR_OPT_ASSIGN] ? src_evt : pre_tick;
    wdt_inc_d   = timer_irq_option_control_q[`CSOIR_OPT_ASSIGN] ? pre_tick : wdt_osc_tick;
    irq_d       = irq_ctl_reg_q[`CSOIR_ICTL_GLOB_EN] && (
      (irq_ctl_reg_q[`CSOIR_ICTL_TMR_EN] && irq_ctl_reg_q[`CSOIR_ICTL_TMR_FLAG]) ||
      (irq_ctl_reg_q[`CSOIR_ICTL_EXT_EN] && irq_ctl_reg_q[`CSOIR_ICTL_EXT_FLAG]) ||
      (irq_ctl_reg_q[`CSOIR_ICTL_PB_EN]  && irq_ctl_reg_q[`CSOIR_ICTL_PB_FLAG])  ||
      (irq_ctl_reg_q[`CSOIR_ICTL_PERI_EN] && periph_irq));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q       <= 1'b0;
      tclk_q      <= 1'b0;
      pre_q       <= 8'h00;
      wr_en_q     <= 1'b0;
      wr_addr_q   <= 9'h000;
      wr_data_q   <= 8'h00;
      w_en_q      <= 1'b0;
      w_data_q    <= 8'h00;
      pullup_en_q <= 1'b0;
      timer_inc_q <= 1'b0;
      wdt_inc_q   <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      ext_q       <= ext_irq_pin;
      tclk_q      <= timer_clk_pin;
      pre_q       <= pre_d;
      wr_en_q     <= wr_en_d;
      wr_addr_q   <= wr_addr_d;
      wr_data_q   <= wr_data_d;
      w_en_q      <= w_en_d;
      w_data_q    <= w_data_d;
      pullup_en_q <= pullup_en_d;
      timer_inc_q <= timer_inc_d;
      wdt_inc_q   <= wdt_inc_d;
      irq_q       <= irq_d;
    end
  end

  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  flag_protect_a:
  assert property (file_wr && op_code == CSOIR_OP_XOR && op_addr == `CSOIR_AFB_ADDR
    |=> alu_flags_bank_select_q[1:0] == $past(alu_flags_bank_select_q[1:0])
        && alu_flags_bank_select_q[`CSOIR_AFB_NULL] == $past(au.z))
    else $error("written result flags not ignored");

  ro_bits_a:
  assert property (file_wr && op_code == CSOIR_OP_MOVE_W && op_addr == `CSOIR_AFB_ADDR
    && !sleep_exec && !clrwdt_exec && !wdt_timeout
    |=> alu_flags_bank_select_q[4:3] == $past(alu_flags_bank_select_q[4:3]))
    else $error("read-only flags changed by write");

  clear_flags_a:
  assert property (file_wr && op_code == CSOIR_OP_CLEAR && op_addr == `CSOIR_AFB_ADDR
    |=> alu_flags_bank_select_q[7:5] == 3'b000
        && alu_flags_bank_select_q[`CSOIR_AFB_NULL]
        && alu_flags_bank_select_q[1:0] == $past(alu_flags_bank_select_q[1:0]))
    else $error("clear on flags register wrong");

  keep_flags_a:
  assert property (op_valid && op_addr != `CSOIR_AFB_ADDR
    && (op_code inside {CSOIR_OP_BIT_CLR, CSOIR_OP_BIT_SET,
                        CSOIR_OP_NIB_SWAP, CSOIR_OP_MOVE_W})
    |=> alu_flags_bank_select_q[2:0] == $past(alu_flags_bank_select_q[2:0]))
    else $error("result flags altered");

  sub_borrow_a:
  assert property (op_valid && op_lit && !op_to_file && op_code == CSOIR_OP_SUB
    |=> alu_flags_bank_select_q[`CSOIR_AFB_OVF] == ($past(w_val) <= $past(file_val))
        && w_en_q)
    else $error("not-borrow wrong after subtract");

  rotate_out_a:
  assert property (op_valid && op_lit && op_code == CSOIR_OP_ROT_R
    |=> alu_flags_bank_select_q[`CSOIR_AFB_OVF] == $past(file_val[0]))
    else $error("rotate did not load carry");

  bank_addr_a:
  assert property (file_wr && !own_hit
    |=> wr_en_q && wr_addr_q == {$past(alu_flags_bank_select_q[6:5]), $past(op_addr)})
    else $error("direct address bank wrong");

  sleep_pwrdn_a:
  assert property (sleep_exec && !clrwdt_exec && !wdt_timeout
    |=> !alu_flags_bank_select_q[`CSOIR_AFB_PWRDN]
        && alu_flags_bank_select_q[`CSOIR_AFB_WDEXP])
    else $error("sleep did not clear powerdown flag");

  ext_edge_a:
  assert property ($rose(ext_irq_pin) && timer_irq_option_control_q[`CSOIR_OPT_IRQ_EDGE]
    |=> irq_ctl_reg_q[`CSOIR_ICTL_EXT_FLAG])
    else $error("rising edge missed");

  timer_src_a:
  assert property (!timer_irq_option_control_q[`CSOIR_OPT_SRC]
    && timer_irq_option_control_q[`CSOIR_OPT_ASSIGN] |=> timer_inc_q)
    else $error("instruction clock not counted");

  flag_set_a:
  assert property (timer_ovf |=> irq_ctl_reg_q[`CSOIR_ICTL_TMR_FLAG])
    else $error("overflow flag not set");

  irq_gate_a:
  assert property (irq_q |-> $past(irq_ctl_reg_q[`CSOIR_ICTL_GLOB_EN]))
    else $error("irq without global enable");

  pullup_pol_a:
  assert property (pullup_en_q != timer_irq_option_control_q[`CSOIR_OPT_PULLUP_N])
    else $error("pull-up polarity wrong");

  ext_fall_a:
  assert property ($fell(ext_irq_pin) && !timer_irq_option_control_q[`CSOIR_OPT_IRQ_EDGE]
    |=> irq_ctl_reg_q[`CSOIR_ICTL_EXT_FLAG])
    else $error("falling edge missed");

  tmr_edge_a:
  assert property (timer_irq_option_control_q[`CSOIR_OPT_SRC]
    && !timer_irq_option_control_q[`CSOIR_OPT_TEDGE]
    && timer_irq_option_control_q[`CSOIR_OPT_ASSIGN] && $rose(timer_clk_pin)
    |=> timer_inc_q)
    else $error("rising timer pin edge missed");

  sleep_c:   cover property (sleep_exec ##1 !alu_flags_bank_select_q[`CSOIR_AFB_PWRDN]);
  tick_c:    cover property (timer_inc_q && !timer_irq_option_control_q[`CSOIR_OPT_ASSIGN]);
  irq_c:     cover property (irq_q);
  opt_wr_c:  cover property (file_wr && hit_opt && dir_addr == `CSOIR_OPT_ADDR_B3);
  fall_c:    cover property (!timer_irq_option_control_q[`CSOIR_OPT_IRQ_EDGE] && ext_edge);

endmodule

/* core/csoir_params.svh */
// Addresses, field positions and reset values of the core flag, option and irq registers
`ifndef CSOIR_PARAMS_SVH
`define CSOIR_PARAMS_SVH

// Direct addresses (flag and irq control low seven bits repeat in every bank; option only in banks 1 and 3)
`define CSOIR_AFB_ADDR      7'h03
`define CSOIR_ICTL_ADDR     7'h0B
`define CSOIR_OPT_ADDR_B1   9'h081
`define CSOIR_OPT_ADDR_B3   9'h181

// Flag and bank select register fields
`define CSOIR_AFB_OVF       0
`define CSOIR_AFB_NIB       1
`define CSOIR_AFB_NULL      2
`define CSOIR_AFB_PWRDN     3
`define CSOIR_AFB_WDEXP     4
`define CSOIR_AFB_BANK_LO   5
`define CSOIR_AFB_BANK_HI   6

// Option register fields
`define CSOIR_OPT_RATE_MSB  2
`define CSOIR_OPT_ASSIGN    3
`define CSOIR_OPT_TEDGE     4
`define CSOIR_OPT_SRC       5
`define CSOIR_OPT_IRQ_EDGE  6
`define CSOIR_OPT_PULLUP_N  7

// Interrupt control fields
`define CSOIR_ICTL_PB_FLAG  0
`define CSOIR_ICTL_EXT_FLAG 1
`define CSOIR_ICTL_TMR_FLAG 2
`define CSOIR_ICTL_PB_EN    3
`define CSOIR_ICTL_EXT_EN   4
`define CSOIR_ICTL_TMR_EN   5
`define CSOIR_ICTL_PERI_EN  6
`define CSOIR_ICTL_GLOB_EN  7

// Reset values
`define CSOIR_AFB_RST       8'h18
`define CSOIR_OPT_RST       8'hFF
`define CSOIR_ICTL_RST      8'h00

`endif

/* core/csoir_pkg.sv */
// Types shared by the core flag, option and irq register logic
package csoir_pkg;

  typedef enum logic [4:0] {
    CSOIR_OP_NONE,
    CSOIR_OP_ADD,
    CSOIR_OP_SUB,
    CSOIR_OP_AND,
    CSOIR_OP_IOR,
    CSOIR_OP_XOR,
    CSOIR_OP_MOVE_F,
    CSOIR_OP_COMPL,
    CSOIR_OP_INC,
    CSOIR_OP_DEC,
    CSOIR_OP_CLEAR,
    CSOIR_OP_ROT_R,
    CSOIR_OP_ROT_L,
    CSOIR_OP_NIB_SWAP,
    CSOIR_OP_MOVE_W,
    CSOIR_OP_BIT_CLR,
    CSOIR_OP_BIT_SET
  } csoir_op_t;

  typedef logic [7:0] csoir_byte_t;

endpackage

/* core/csoir_alu_if.sv */
// Operands and flag results passed between the register block and its arithmetic unit
`timescale 1ns/100ps
interface csoir_alu_if;
  import csoir_pkg::*;
  csoir_op_t   op;
  csoir_byte_t a;
  csoir_byte_t b;
  logic [2:0]  bsel;
  logic        cin;
  csoir_byte_t res;
  logic        z;
  logic        dc;
  logic        c;
  logic        upd_z;
  logic        upd_dc;
  logic        upd_c;
  modport core (output op, a, b, bsel, cin,
                input  res, z, dc, c, upd_z, upd_dc, upd_c);
  modport alu  (input  op, a, b, bsel, cin,
                output res, z, dc, c, upd_z, upd_dc, upd_c);
endinterface

/* core/csoir_alu.sv */
// Arithmetic unit producing the result byte and the three result flags
`timescale 1ns/100ps
module csoir_alu
  import csoir_pkg::*;
(
  // Operands in, result and flags out
  csoir_alu_if.alu au
);

  logic [7:0] addend;
  logic       sub_cin;
  logic [8:0] sum;
  logic [4:0] lsum;

  // Subtract as add of two's complement; carries become not-borrow
  always_comb begin
    sub_cin = (au.op == CSOIR_OP_SUB);
    addend  = sub_cin ? ~au.b : au.b;
    sum     = {1'b0, au.a} + {1'b0, addend} + {8'h00, sub_cin};
    lsum    = {1'b0, au.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_cin};
  end

  always_comb begin
    au.res    = au.a;
    au.c      = sum[8];
    au.dc     = lsum[4];
    au.upd_z  = 1'b0;
    au.upd_dc = 1'b0;
    au.upd_c  = 1'b0;
    case (au.op)
      CSOIR_OP_ADD, CSOIR_OP_SUB: begin
        au.res    = sum[7:0];
        au.upd_z  = 1'b1;
        au.upd_dc = 1'b1;
        au.upd_c  = 1'b1;
      end
      CSOIR_OP_AND: begin
        au.res   = au.a & au.b;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_IOR: begin
        au.res   = au.a | au.b;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_XOR: begin
        au.res   = au.a ^ au.b;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_MOVE_F: au.upd_z = 1'b1;
      CSOIR_OP_COMPL: begin
        au.res   = ~au.a;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_INC: begin
        au.res   = au.a + 8'h01;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_DEC: begin
        au.res   = au.a - 8'h01;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_CLEAR: begin
        au.res   = 8'h00;
        au.upd_z = 1'b1;
      end
      CSOIR_OP_ROT_R: begin
        au.res   = {au.cin, au.a[7:1]};
        au.c     = au.a[0];
        au.upd_c = 1'b1;
      end
      CSOIR_OP_ROT_L: begin
        au.res   = {au.a[6:0], au.cin};
        au.c     = au.a[7];
        au.upd_c = 1'b1;
      end
      // These four leave every result flag alone
      CSOIR_OP_NIB_SWAP: au.res = {au.a[3:0], au.a[7:4]};
      CSOIR_OP_MOVE_W:   au.res = au.b;
      CSOIR_OP_BIT_CLR:  au.res = au.a & ~(8'h01 << au.bsel);
      CSOIR_OP_BIT_SET:  au.res = au.a | (8'h01 << au.bsel);
      default:           au.res = au.a;
    endcase
    au.z = ~|au.res;
  end

endmodule

/* test/csoir_regs_tb_top.sv */
// Self-checking bench for the core flag, option and irq registers
`timescale 1ns/100ps
`include "csoir_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module csoir_regs_tb_top
  import csoir_pkg::*;
;
  logic        core_clk;
  logic        rst_n;
  logic        op_valid;
  csoir_op_t   op_code;
  logic        op_lit;
  logic        op_to_file;
  logic [6:0]  op_addr;
  logic [2:0]  op_bit;
  csoir_byte_t w_val;
  csoir_byte_t file_val;
  logic        sleep_exec;
  logic        clrwdt_exec;
  logic        wdt_timeout;
  logic        wdt_osc_tick;
  logic        ext_irq_pin;
  logic        timer_clk_pin;
  logic        timer_ovf;
  logic        portb_change;
  logic        periph_irq;
  csoir_byte_t wr_data_q;
  logic [8:0]  wr_addr_q;
  logic        wr_en_q;
  csoir_byte_t w_data_q;
  logic        w_en_q;
  csoir_byte_t afb;
  csoir_byte_t opt;
  csoir_byte_t ictl;
  logic        pullup_en_q;
  logic        timer_inc_q;
  logic        wdt_inc_q;
  logic        irq_q;
  int          n_errors;
  int          n_tests;

  csoir_regs uut (
    .core_clk, .rst_n, .op_valid, .op_code, .op_lit, .op_to_file, .op_addr, .op_bit,
    .w_val, .file_val, .sleep_exec, .clrwdt_exec, .wdt_timeout, .wdt_osc_tick,
    .ext_irq_pin, .timer_clk_pin, .timer_ovf, .portb_change, .periph_irq,
    .wr_data_q, .wr_addr_q, .wr_en_q, .w_data_q, .w_en_q,
    .alu_flags_bank_select_q(afb), .timer_irq_option_control_q(opt),
    .irq_ctl_reg_q(ictl), .pullup_en_q, .timer_inc_q, .wdt_inc_q, .irq_q
  );

  always #20 core_clk = ~core_clk;

  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask

  // One instruction for one cycle; results are settled on return
  task automatic op(csoir_op_t c, logic l, logic f, logic [6:0] a, logic [2:0] b,
                    csoir_byte_t wv, csoir_byte_t fv);
    @(negedge core_clk);
    op_valid = 1'b1;
    op_code = c;
    op_lit = l;
    op_to_file = f;
    op_addr = a;
    op_bit = b;
    w_val = wv;
    file_val = fv;
    @(negedge core_clk);
    op_valid = 1'b0;
    op_code = CSOIR_OP_NONE;
  endtask

  task automatic wr_afb(csoir_byte_t v);
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, `CSOIR_AFB_ADDR, 3'h0, v, 8'h00);
  endtask

  task automatic cnt(int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (timer_inc_q === 1'b1) k++;
    end
  endtask

  task automatic t_reset();
    `CHK(afb, 8'h18)
    `CHK(opt, 8'hFF)
    `CHK(ictl, 8'h00)
    `CHK(pullup_en_q, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_flag_write();
    wr_afb(8'h25);
    `CHK(afb, 8'h3D)
    op(CSOIR_OP_CLEAR, 1'b0, 1'b1, `CSOIR_AFB_ADDR, 3'h0, 8'h00, 8'h00);
    `CHK(afb, 8'h1D)
    `CHK(wr_en_q, 1'b0)
    op(CSOIR_OP_ADD, 1'b0, 1'b1, `CSOIR_AFB_ADDR, 3'h0, 8'h20, 8'h00);
    `CHK(afb, 8'h38)
    op(CSOIR_OP_XOR, 1'b0, 1'b1, `CSOIR_AFB_ADDR, 3'h0, 8'h38, 8'h00);
    `CHK(afb, 8'h1C)
    wr_afb(8'h00);
    `CHK(afb, 8'h18)
    $display("test flag write done");
  endtask

  task automatic t_sub();
    csoir_byte_t ks[3] = '{8'h10, 8'h05, 8'h00};
    csoir_byte_t ws[3] = '{8'h01, 8'h05, 8'h01};
    csoir_byte_t rs[3] = '{8'h0F, 8'h00, 8'hFF};
    logic [2:0]  fs[3] = '{3'h1, 3'h7, 3'h0};
    for (int i = 0; i < 3; i++) begin
      op(CSOIR_OP_SUB, 1'b1, 1'b0, 7'h00, 3'h0, ws[i], ks[i]);
      `CHK(w_en_q, 1'b1)
      `CHK(w_data_q, rs[i])
      `CHK(afb[2:0], fs[i])
    end
    $display("test subtract done");
  endtask

  task automatic t_rotate();
    op(CSOIR_OP_ROT_L, 1'b1, 1'b0, 7'h00, 3'h0, 8'h00, 8'h80);
    `CHK(w_data_q, 8'h00)
    `CHK(afb[0], 1'b1)
    op(CSOIR_OP_ROT_R, 1'b1, 1'b0, 7'h00, 3'h0, 8'h00, 8'h01);
    `CHK(w_data_q, 8'h80)
    `CHK(afb[0], 1'b1)
    $display("test rotate done");
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr_afb({1'b0, 2'(b), 5'h07});
      op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h20, 3'h0, 8'h5A, 8'h00);
      `CHK(wr_en_q, 1'b1)
      `CHK(wr_addr_q, {2'(b), 7'h20})
      `CHK(wr_data_q, 8'h5A)
      op(CSOIR_OP_BIT_SET, 1'b0, 1'b1, 7'h20, 3'(b), 8'h00, 8'h00);
      `CHK(wr_data_q, 8'(1 << b))
      op(CSOIR_OP_NIB_SWAP, 1'b0, 1'b1, 7'h20, 3'h0, 8'h00, 8'h3C);
      `CHK(wr_data_q, 8'hC3)
      `CHK(afb[2:0], 3'h7)
    end
    $display("test banks done");
  endtask

  task automatic t_option();
    wr_afb(8'h20);
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'h7F, 8'h00);
    `CHK(opt, 8'h7F)
    `CHK(wr_en_q, 1'b0)
    `CHK(pullup_en_q, 1'b1)
    op(CSOIR_OP_NIB_SWAP, 1'b0, 1'b0, 7'h01, 3'h0, 8'h00, 8'h00);
    `CHK(w_data_q, 8'hF7)
    wr_afb(8'h60);
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'hFF, 8'h00);
    `CHK(opt, 8'hFF)
    `CHK(pullup_en_q, 1'b0)
    wr_afb(8'h00);
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'h00, 8'h00);
    `CHK(wr_en_q, 1'b1)
    `CHK(opt, 8'hFF)
    $display("test option done");
  endtask

  task automatic t_events();
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
    cyc(1);
    `CHK(afb[4:3], 2'b10)
    wdt_timeout = 1'b1;
    cyc(1);
    wdt_timeout = 1'b0;
    cyc(1);
    `CHK(afb[4:3], 2'b00)
    clrwdt_exec = 1'b1;
    cyc(1);
    clrwdt_exec = 1'b0;
    cyc(1);
    `CHK(afb[4:3], 2'b11)
    $display("test events done");
  endtask

  task automatic t_irq();
    timer_ovf = 1'b1;
    portb_change = 1'b1;
    cyc(1);
    timer_ovf = 1'b0;
    portb_change = 1'b0;
    cyc(2);
    `CHK(ictl, 8'h05)
    `CHK(irq_q, 1'b0)
    op(CSOIR_OP_NIB_SWAP, 1'b0, 1'b0, `CSOIR_ICTL_ADDR, 3'h0, 8'h00, 8'h00);
    `CHK(w_data_q, 8'h50)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, `CSOIR_ICTL_ADDR, 3'h0, 8'h00, 8'h00);
    ext_irq_pin = 1'b1;
    cyc(3);
    `CHK(ictl, 8'h02)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, `CSOIR_ICTL_ADDR, 3'h0, 8'h00, 8'h00);
    ext_irq_pin = 1'b0;
    cyc(3);
    `CHK(ictl, 8'h00)
    periph_irq = 1'b1;
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, `CSOIR_ICTL_ADDR, 3'h0, 8'hC0, 8'h00);
    cyc(2);
    `CHK(irq_q, 1'b1)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, `CSOIR_ICTL_ADDR, 3'h0, 8'h80, 8'h00);
    cyc(2);
    `CHK(irq_q, 1'b0)
    periph_irq = 1'b0;
    $display("test irq done");
  endtask

  task automatic t_timer();
    int k;
    wr_afb(8'h20);
    timer_clk_pin = 1'b1;
    cnt(4, k);
    `CHK(k, 0)
    timer_clk_pin = 1'b0;
    cnt(4, k);
    `CHK(k, 1)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'hA8, 8'h00);
    timer_clk_pin = 1'b1;
    ext_irq_pin = 1'b1;
    cnt(4, k);
    `CHK(k, 1)
    `CHK(ictl, 8'h80)
    timer_clk_pin = 1'b0;
    ext_irq_pin = 1'b0;
    cnt(4, k);
    `CHK(k, 0)
    `CHK(ictl, 8'h82)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'hC0, 8'h00);
    cnt(20, k);
    `CHK(k, 10)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'hC2, 8'h00);
    cnt(40, k);
    `CHK(k, 5)
    op(CSOIR_OP_MOVE_W, 1'b0, 1'b1, 7'h01, 3'h0, 8'hC8, 8'h00);
    cnt(10, k);
    `CHK(k, 10)
    wdt_osc_tick = 1'b1;
    cyc(1);
    `CHK(wdt_inc_q, 1'b1)
    wdt_osc_tick = 1'b0;
    cyc(1);
    `CHK(wdt_inc_q, 1'b0)
    $display("test timer done");
  endtask

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is just under two hundred cycles
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {core_clk, rst_n, op_valid, op_lit, op_to_file, sleep_exec, clrwdt_exec} = '0;
    {wdt_timeout, wdt_osc_tick, ext_irq_pin, timer_clk_pin, timer_ovf} = '0;
    {portb_change, periph_irq, op_addr, op_bit, w_val, file_val} = '0;
    op_code = CSOIR_OP_NONE;
    n_errors = 0;
    n_tests = 0;
    cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_flag_write();
    t_sub();
    t_rotate();
    t_banks();
    t_option();
    t_events();
    t_irq();
    t_timer();
    tally_and_finish();
  end
endmodule
